// [core/compare_pkg.sv]
// Purpose: Shared constants for the integer compare unit
// Assumes: 32-bit datapath, register-type field layout below
// Notes: Immediate-type opcodes sit in the low six bits as well
package compare_pkg;
   localparam int DATA_W = 32;
   localparam int IMM_W = 16;
   // Register-type field positions
   localparam int SRC_A_HI = 31;
   localparam int SRC_A_LO = 27;
   localparam int SRC_B_HI = 26;
   localparam int SRC_B_LO = 22;
   localparam int DST_C_HI = 21;
   localparam int DST_C_LO = 17;
   localparam int EXT_OP_HI = 16;
   localparam int EXT_OP_LO = 11;
   localparam int SHIFT_HI = 10;
   localparam int SHIFT_LO = 6;
   localparam int PRIM_OP_HI = 5;
   localparam int PRIM_OP_LO = 0;
   localparam int IMM_HI = 21;
   localparam int IMM_LO = 6;
   // Opcodes
   localparam logic [5:0] OP_RTYPE = 6'h3a;
   localparam logic [5:0] EXT_SIGNED_LT = 6'h10;
   localparam logic [5:0] EXT_SIGNED_GE = 6'h08;
   localparam logic [5:0] EXT_UNSIGNED_GE = 6'h28;
   localparam logic [5:0] EXT_UNSIGNED_LT = 6'h30;
   localparam logic [4:0] SHIFT_ZERO = 5'h00;
   localparam logic [5:0] OP_SIGNED_GE_IMM = 6'h08;
   localparam logic [5:0] OP_UNSIGNED_GE_IMM = 6'h28;
   localparam logic [5:0] OP_SIGNED_LT_IMM = 6'h10;
   localparam logic [5:0] OP_UNSIGNED_LT_IMM = 6'h30;
   // Compare kinds
   typedef enum logic [1:0] {
      CMP_LT = 2'b00,
      CMP_GE = 2'b01
   } cmp_kind_t;
endpackage : compare_pkg

// [core/integer_compare_unit.sv]
// Purpose: Compare unit of the integer datapath, one result per instruction
// Assumes: Operands are read from the register file in the issue cycle
// Notes: Result is registered, valid one cycle after issue
`timescale 1ns/100ps
module integer_compare_unit #(
   parameter int DATA_W = compare_pkg::DATA_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Issue
   input wire logic issueValid,
   input wire logic [31:0] instrWord,
   input wire logic [DATA_W-1:0] src_a_reg,
   input wire logic [DATA_W-1:0] reg_b,
   // Result
   output logic resultValid,
   output logic [DATA_W-1:0] resultData,
   output logic [4:0] resultDest,
   output logic illegalOp
);
   // Elaboration checks: the datapath width and the field map are fixed
   initial begin
      if (DATA_W != compare_pkg::DATA_W) begin
         $error("integer_compare_unit supports only a 32-bit datapath");
      end
      if (compare_pkg::IMM_HI - compare_pkg::IMM_LO + 1 != compare_pkg::IMM_W) begin
         $error("integer_compare_unit immediate field does not match its width");
      end
      // Register-type fields must tile the word with no gap or overlap
      if (compare_pkg::SRC_A_LO != compare_pkg::SRC_B_HI + 1 ||
          compare_pkg::SRC_B_LO != compare_pkg::DST_C_HI + 1 ||
          compare_pkg::DST_C_LO != compare_pkg::EXT_OP_HI + 1 ||
          compare_pkg::EXT_OP_LO != compare_pkg::SHIFT_HI + 1 ||
          compare_pkg::SHIFT_LO != compare_pkg::PRIM_OP_HI + 1) begin
         $error("integer_compare_unit field map has a gap or overlap");
      end
   end

   // Field extraction
   wire logic [5:0] primOp = instrWord[compare_pkg::PRIM_OP_HI:compare_pkg::PRIM_OP_LO];
   wire logic [5:0] extOp = instrWord[compare_pkg::EXT_OP_HI:compare_pkg::EXT_OP_LO];
   wire logic [4:0] shiftField = instrWord[compare_pkg::SHIFT_HI:compare_pkg::SHIFT_LO];
   wire logic [4:0] fieldB = instrWord[compare_pkg::SRC_B_HI:compare_pkg::SRC_B_LO];
   wire logic [4:0] fieldC = instrWord[compare_pkg::DST_C_HI:compare_pkg::DST_C_LO];
   wire logic [15:0] immediate_value = instrWord[compare_pkg::IMM_HI:compare_pkg::IMM_LO];

   // Decode; the swapped pseudo forms arrive already as base opcodes
   wire logic isRtype = (primOp == compare_pkg::OP_RTYPE) &&
                        (shiftField == compare_pkg::SHIFT_ZERO);
   wire logic rSignedLt = isRtype && (extOp == compare_pkg::EXT_SIGNED_LT);
   wire logic rSignedGe = isRtype && (extOp == compare_pkg::EXT_SIGNED_GE);
   wire logic rUnsignedLt = isRtype && (extOp == compare_pkg::EXT_UNSIGNED_LT);
   wire logic rUnsignedGe = isRtype && (extOp == compare_pkg::EXT_UNSIGNED_GE);
   wire logic iSignedGe = primOp == compare_pkg::OP_SIGNED_GE_IMM;
   wire logic iUnsignedGe = primOp == compare_pkg::OP_UNSIGNED_GE_IMM;
   wire logic iSignedLt = primOp == compare_pkg::OP_SIGNED_LT_IMM;
   wire logic iUnsignedLt = primOp == compare_pkg::OP_UNSIGNED_LT_IMM;
   wire logic isRegForm = rSignedLt | rSignedGe | rUnsignedLt | rUnsignedGe;
   wire logic isImmForm = iSignedGe | iUnsignedGe | iSignedLt | iUnsignedLt;
   wire logic decodeHit = isRegForm | isImmForm;

   // Issue outcome: a decoded issue gives a result, anything else a refusal
   wire logic acceptIssue = issueValid && decodeHit;
   wire logic refuseIssue = issueValid && !decodeHit;

   // Operand shaping: sign or zero extension of the immediate
   wire logic immSigned = iSignedGe | iSignedLt;
   wire logic [DATA_W-1:0] immExt = immSigned ?
      {{(DATA_W - 16){immediate_value[15]}}, immediate_value} :
      {{(DATA_W - 16){1'b0}}, immediate_value};
   // Immediate forms ignore reg_b; register forms ignore the immediate bits
   wire logic [DATA_W-1:0] rhsOperand = isImmForm ? immExt : reg_b;
   wire logic signedCmp = rSignedLt | rSignedGe | immSigned;
   wire logic wantGe = rSignedGe | rUnsignedGe | iSignedGe | iUnsignedGe;
   wire logic [4:0] destSel = isImmForm ? fieldB : fieldC;

   // Shared magnitude comparator
   wire logic aLessB;
   magnitude_compare #(
      .WIDTH(DATA_W)
   ) u_cmp (
      .lhs(src_a_reg),
      .rhs(rhsOperand),
      .isSigned(signedCmp),
      .lessThan(aLessB)
   );

   // Greater-or-equal is the inverse of less-than
   wire logic cmpBit = wantGe ? ~aLessB : aLessB;
   wire logic [DATA_W-1:0] next_resultData = {{(DATA_W - 1){1'b0}}, cmpBit};

   // Result register; data holds its last value when nothing issues
   // Holding saves a write-back mux and lets a refused issue leave no trace
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resultValid <= 1'b0;
         resultData <= '0;
         resultDest <= 5'h00;
         illegalOp <= 1'b0;
      end else begin
         resultValid <= acceptIssue;
         illegalOp <= refuseIssue;
         if (acceptIssue) begin
            resultData <= next_resultData;
            resultDest <= destSel;
         end
      end
   end

   // Checks
   AST_SLT_REG: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rSignedLt |=> resultValid &&
      resultData == {31'h0, $signed($past(src_a_reg)) < $signed($past(reg_b))})
      else $error("signed less-than register result wrong");
   AST_SLT_DECODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && primOp == 6'h3a && extOp == 6'h10 && shiftField == 5'h00
      |=> resultValid && resultDest == $past(instrWord[21:17]))
      else $error("signed less-than register not decoded");
   AST_FIELDS: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && instrWord[5:0] == 6'h3a && instrWord[10:6] != 5'h00 |=> illegalOp)
      else $error("nonzero shift field accepted");

   // Swapped-operand base forms on register operands
   AST_ULT_REG: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rUnsignedLt |=> resultData[0] == ($past(src_a_reg) < $past(reg_b)))
      else $error("unsigned less-than register result wrong");
   AST_SGE_REG: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rSignedGe |=>
      resultData[0] == ($signed($past(src_a_reg)) >= $signed($past(reg_b))))
      else $error("signed ge register result wrong");
   AST_UGE_REG: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rUnsignedGe |=> resultData[0] == ($past(src_a_reg) >= $past(reg_b)))
      else $error("unsigned ge register result wrong");

   // Immediate forms, checked against the raw immediate bits
   AST_UGE_IMM: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iUnsignedGe |=> resultDest == $past(instrWord[26:22]) &&
      resultData[0] == ($past(src_a_reg) >= {16'h0, $past(instrWord[21:6])}))
      else $error("unsigned ge immediate result wrong");
   AST_SLT_IMM: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iSignedLt |=> resultData[0] ==
      ($signed($past(src_a_reg)) < $signed({{16{$past(instrWord[21])}}, $past(instrWord[21:6])})))
      else $error("signed lt immediate result wrong");
   AST_ULT_IMM: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iUnsignedLt |=>
      resultData[0] == ($past(src_a_reg) < {16'h0, $past(instrWord[21:6])}))
      else $error("unsigned lt immediate result wrong");

   // Register forms name the C field, immediate forms the B field
   AST_REG_DEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && isRegForm
      |=> resultValid && resultDest == $past(instrWord[21:17]))
      else $error("register form destination wrong");
   AST_IMM_DEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && isImmForm
      |=> resultValid && resultDest == $past(instrWord[26:22]))
      else $error("immediate form destination wrong");

   // Signed greater-or-equal immediate shares the sign-extension path
   AST_SGE_IMM: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iSignedGe |=> resultData[0] ==
      ($signed($past(src_a_reg)) >=
       $signed({{16{$past(instrWord[21])}}, $past(instrWord[21:6])})))
      else $error("signed ge immediate result wrong");

   // Equal operands: the swapped le forms answer 1, the lt and gt forms 0
   AST_SGE_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rSignedGe && src_a_reg == reg_b |=> resultData[0])
      else $error("signed ge on equal operands gave 0");
   AST_UGE_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rUnsignedGe && src_a_reg == reg_b |=> resultData[0])
      else $error("unsigned ge on equal operands gave 0");
   AST_ULT_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rUnsignedLt && src_a_reg == reg_b |=> !resultData[0])
      else $error("unsigned lt on equal operands gave 1");
   AST_SLT_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && rSignedLt && src_a_reg == reg_b |=> !resultData[0])
      else $error("signed lt on equal operands gave 1");

   // Equal immediate: the ge form answers 1, the lt form 0
   AST_UGE_IMM_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iUnsignedGe && src_a_reg == {16'h0, instrWord[21:6]} |=> resultData[0])
      else $error("unsigned ge immediate on equal value gave 0");
   AST_SLT_IMM_EQUAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && iSignedLt && src_a_reg == {{16{instrWord[21]}}, instrWord[21:6]}
      |=> !resultData[0])
      else $error("signed lt immediate on equal value gave 1");

   // Only bit 0 carries the answer; the upper bits stay clear
   AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
      resultData[DATA_W-1:1] == '0)
      else $error("result has upper bits set");

   // Outside an accepted issue the result and destination hold
   AST_DATA_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !resultValid |-> $stable(resultData) && $stable(resultDest))
      else $error("result changed without an accepted issue");

   // Without an issue nothing answers; never both answers at once
   AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !issueValid |=> !resultValid && !illegalOp)
      else $error("answer without an issue");
   AST_ONE_ANSWER: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(resultValid && illegalOp))
      else $error("result and refusal shown together");

   // Primary opcodes outside the compare set are refused
   AST_UNKNOWN_OP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && !(instrWord[5:0] inside {6'h3a, 6'h08, 6'h28, 6'h10, 6'h30})
      |=> illegalOp && !resultValid)
      else $error("unknown opcode not refused");

   // Register-type words with an extension outside the set are refused
   AST_UNKNOWN_EXT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      issueValid && instrWord[5:0] == 6'h3a &&
      !(instrWord[16:11] inside {6'h10, 6'h08, 6'h30, 6'h28})
      |=> illegalOp && !resultValid)
      else $error("unknown extension not refused");
endmodule : integer_compare_unit

// [core/magnitude_compare.sv]
// Purpose: Signed or unsigned less-than of two words
// Assumes: Purely combinational
// Notes: Signed compare flips both sign bits and reuses the unsigned path
`timescale 1ns/100ps
module magnitude_compare #(
   parameter int WIDTH = 32
) (
   // Operands
   input wire logic [WIDTH-1:0] lhs,
   input wire logic [WIDTH-1:0] rhs,
   input wire logic isSigned,
   // Result
   output logic lessThan
);
   initial begin
      if (WIDTH < 2) begin
         $error("magnitude_compare needs at least two bits");
      end
   end

   // Inverting the sign bits maps signed order onto unsigned order
   wire logic [WIDTH-1:0] biasA = {lhs[WIDTH-1] ^ isSigned, lhs[WIDTH-2:0]};
   wire logic [WIDTH-1:0] biasB = {rhs[WIDTH-1] ^ isSigned, rhs[WIDTH-2:0]};
   assign lessThan = biasA < biasB;
endmodule : magnitude_compare

// [dv/tb.sv]
// Purpose: Self-checking bench for the integer compare unit
// Assumes: Result shows 1 ns after the taking edge
// Notes: Pseudo forms are issued as the base form a compiler would emit
`timescale 1ns/100ps
module tb;
   logic clk_sys, reset_n, issueValid, resultValid, illegalOp;
   logic [31:0] instrWord, srcA, regB, resultData;
   logic [4:0] resultDest;
   int n_fail = 0;
   int num_checks = 0;
   integer_compare_unit dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .issueValid(issueValid),
      .instrWord(instrWord), .src_a_reg(srcA), .reg_b(regB), .resultValid(resultValid),
      .resultData(resultData), .resultDest(resultDest), .illegalOp(illegalOp));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Register form writes C (index 3), immediate form writes B (index 2)
   function automatic logic [31:0] rt(input logic [5:0] ext, input logic [4:0] sh);
      return {5'h01, 5'h02, 5'h03, ext, sh, compare_pkg::OP_RTYPE};
   endfunction
   function automatic logic [31:0] it(input logic [5:0] op, input logic [15:0] imm);
      return {5'h01, 5'h02, imm, op};
   endfunction
   // Valid is left high so issues run back to back; idle drops it
   task automatic issue(input logic [31:0] w, a, b, input logic e, input logic [4:0] d);
      issueValid = 1'b1;
      instrWord = w;
      srcA = a;
      regB = b;
      @(posedge clk_sys);
      #1;
      chk({31'h0, resultValid}, 32'h1);
      chk(resultData, {31'h0, e});
      chk({27'h0, resultDest}, {27'h0, d});
   endtask
   task automatic idle;
      issueValid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic t_lt;
      issue(rt(compare_pkg::EXT_SIGNED_LT, 5'h00), 32'hffffffff, 32'h1, 1'b1, 5'h03);
      issue(rt(compare_pkg::EXT_SIGNED_LT, 5'h00), 32'h1, 32'hffffffff, 1'b0, 5'h03);
      issue(rt(compare_pkg::EXT_SIGNED_LT, 5'h00), 32'h80000000, 32'h7fffffff, 1'b1, 5'h03);
      issue(rt(compare_pkg::EXT_SIGNED_LT, 5'h00), 32'h5, 32'h5, 1'b0, 5'h03);
      idle();
   endtask
   // Swapped operands: greater-than unsigned, less-or-equal signed and unsigned
   task automatic t_swap;
      issue(rt(compare_pkg::EXT_UNSIGNED_LT, 5'h00), 32'h1, 32'hffffffff, 1'b1, 5'h03);
      issue(rt(compare_pkg::EXT_UNSIGNED_LT, 5'h00), 32'h7, 32'h7, 1'b0, 5'h03);
      issue(rt(compare_pkg::EXT_SIGNED_GE, 5'h00), 32'hfffffffb, 32'hfffffffb, 1'b1, 5'h03);
      issue(rt(compare_pkg::EXT_SIGNED_GE, 5'h00), 32'hffffffff, 32'h1, 1'b0, 5'h03);
      issue(rt(compare_pkg::EXT_UNSIGNED_GE, 5'h00), 32'h80000000, 32'h3, 1'b1, 5'h03);
      issue(rt(compare_pkg::EXT_UNSIGNED_GE, 5'h00), 32'h0, 32'hffffffff, 1'b0, 5'h03);
      issue(rt(compare_pkg::EXT_UNSIGNED_GE, 5'h00), 32'h80000000, 32'h80000000, 1'b1, 5'h03);
      idle();
   endtask
   // Immediate forms at their boundary values, encoded with immediate plus one
   task automatic t_imm;
      issue(it(compare_pkg::OP_UNSIGNED_GE_IMM, 16'hffff), 32'hffff, 32'h0, 1'b1, 5'h02);
      issue(it(compare_pkg::OP_UNSIGNED_GE_IMM, 16'hffff), 32'hfffe, 32'h0, 1'b0, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_LT_IMM, 16'h7fff), 32'h7ffe, 32'h0, 1'b1, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_LT_IMM, 16'h7fff), 32'h7fff, 32'h0, 1'b0, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_LT_IMM, 16'h8000), 32'hffff7fff, 32'h0, 1'b1, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_LT_IMM, 16'h8000), 32'hffff8000, 32'h0, 1'b0, 5'h02);
      issue(it(compare_pkg::OP_UNSIGNED_LT_IMM, 16'hffff), 32'hfffe, 32'h0, 1'b1, 5'h02);
      issue(it(compare_pkg::OP_UNSIGNED_LT_IMM, 16'hffff), 32'h7fffffff, 32'h0, 1'b0, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_GE_IMM, 16'hff9c), 32'hffffff9c, 32'h0, 1'b1, 5'h02);
      issue(it(compare_pkg::OP_SIGNED_GE_IMM, 16'hff9c), 32'hffffff9b, 32'h0, 1'b0, 5'h02);
      idle();
   endtask
   // Nonzero shift field, unknown opcode and unknown extension are not compares: no result, data held
   task automatic t_bad;
      issue(rt(compare_pkg::EXT_SIGNED_LT, 5'h00), 32'hffffffff, 32'h1, 1'b1, 5'h03);
      instrWord = rt(compare_pkg::EXT_SIGNED_LT, 5'h01);
      srcA = 32'h1;
      @(posedge clk_sys);
      #1;
      chk({31'h0, illegalOp}, 32'h1);
      chk({31'h0, resultValid}, 32'h0);
      chk(resultData, 32'h1);
      chk({27'h0, resultDest}, 32'h3);
      instrWord = {5'h01, 5'h02, 16'h0, 6'h00};
      @(posedge clk_sys);
      #1;
      chk({30'h0, illegalOp, resultValid}, 32'h2);
      instrWord = rt(6'h3f, 5'h00);
      @(posedge clk_sys);
      #1;
      chk({30'h0, illegalOp, resultValid}, 32'h2);
      chk(resultData, 32'h1);
      idle();
   endtask
   // Reset in mid-run clears every output; an issue right after release is taken
   task automatic t_reset;
      issue(rt(compare_pkg::EXT_UNSIGNED_GE, 5'h00), 32'h9, 32'h4, 1'b1, 5'h03);
      issueValid = 1'b0;
      reset_n = 1'b0;
      #2;
      chk({25'h0, illegalOp, resultValid, resultDest}, 32'h0);
      chk(resultData, 32'h0);
      repeat (2) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      issue(it(compare_pkg::OP_UNSIGNED_LT_IMM, 16'h0001), 32'h0, 32'h0, 1'b1, 5'h02);
      idle();
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog: the run needs under a hundred cycles
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
   // Main sequence
   initial begin
      reset_n = 1'b0;
      issueValid = 1'b0;
      instrWord = 32'h0;
      srcA = 32'h0;
      regB = 32'h0;
      repeat (20) @(posedge clk_sys);
      #1;
      chk({25'h0, illegalOp, resultValid, resultDest}, 32'h0);
      chk(resultData, 32'h0);
      reset_n = 1'b1;
      t_lt();
      t_swap();
      t_imm();
      t_bad();
      t_reset();
      summarize();
   end
endmodule : tb
